/* logic/fcm_defines.svh */
// Offsets, fields, reset values, function codes and timing counts of the frequency modifier
`ifndef FCM_DEFINES_SVH
`define FCM_DEFINES_SVH

// Register byte offsets
`define FCM_OFS_CTRL     8'h00
`define FCM_OFS_FSET     8'h04
`define FCM_OFS_FMAX     8'h08
`define FCM_OFS_OFFSET   8'h0c
`define FCM_OFS_ACCEL    8'h10
`define FCM_OFS_DECEL    8'h14
`define FCM_OFS_INSEL_A  8'h18
`define FCM_OFS_INSEL_B  8'h1c
`define FCM_OFS_STATUS   8'h20

// Control register fields
`define FCM_CTRL_FSRC_LSB   0
`define FCM_CTRL_RSRC_LSB   8
`define FCM_CTRL_MEM_BIT    16
`define FCM_CTRL_SET2_BIT   17

// Status register fields
`define FCM_STAT_OVR_BIT    16
`define FCM_STAT_UDM_BIT    17
`define FCM_STAT_RUN_BIT    18
`define FCM_STAT_STOP_BIT   19
`define FCM_STAT_PIN_LSB    24

// Source encodings
`define FCM_SRC_OPERATOR    2'h2

// Reset values
`define FCM_RST_CTRL     32'h0000_0002
`define FCM_RST_FSET     16'h0000
`define FCM_RST_FMAX     16'h1770
`define FCM_RST_RAMP     16'h03e8
`define FCM_RST_INSEL_A  32'h1f1d_1c1b
`define FCM_RST_INSEL_B  32'h0000_0632

// Intelligent input function codes
`define FCM_FN_UP    8'h1b
`define FCM_FN_DOWN  8'h1c
`define FCM_FN_CLR   8'h1d
`define FCM_FN_OVR   8'h1f
`define FCM_FN_ADD   8'h32
`define FCM_FN_JOG   8'h06

// Timing
`define FCM_CLK_NS       4
`define FCM_TICK_NS      1000
`define FCM_TICK_CYC     (`FCM_TICK_NS / `FCM_CLK_NS)
`define FCM_DEBOUNCE_NS  5000000
`define FCM_DEBOUNCE_CYC (`FCM_DEBOUNCE_NS / `FCM_CLK_NS)

`endif

/* logic/fcm_pkg.sv */
// Types shared by the frequency modifier files
package fcm_pkg;
	// Override hand-over sequence; one bit changes per step except FCM_APPLY back to FCM_NORMAL
	typedef enum logic [1:0] {
		FCM_NORMAL   = 2'b00,
		FCM_STOPPING = 2'b01,
		FCM_APPLY    = 2'b11
	} fcm_state_type;
endpackage

/* logic/fcm_pin_filter.sv */
// Three-stage synchroniser and stability filter for the intelligent input pins
`timescale 1ns/10ps
`default_nettype none
module fcm_pin_filter
	import fcm_pkg::*;
#(
	parameter int WIDTH = 6,
	parameter int STABLE_CYC = 1250000
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Raw pins and filtered levels
	input  wire logic [WIDTH-1:0] pin_raw,
	output logic      [WIDTH-1:0] pin_clean
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [31:0]      cnt_r [WIDTH];

	// Three flops; the first is read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change counts once stages two and three agree for the whole window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_clean <= '0;
			for (int i = 0; i < WIDTH; i++) cnt_r[i] <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_r[i] != s3_r[i] || s3_r[i] == pin_clean[i]) begin
					cnt_r[i] <= '0;
				end else if (cnt_r[i] >= 32'(STABLE_CYC - 1)) begin
					cnt_r[i]     <= '0;
					pin_clean[i] <= s3_r[i];
				end else begin
					cnt_r[i] <= cnt_r[i] + 32'd1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* logic/fcm_top.sv */
// Frequency command modifier: up/down ramp, operator override and offset addition
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "fcm_defines.svh"
module fcm_top
	import fcm_pkg::*;
#(
	parameter int NPIN = 6,
	parameter int DEBOUNCE_CYC = `FCM_DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Intelligent input pins
	input  wire logic [NPIN-1:0] input_pins,
	// Operator panel, same clock
	input  wire logic [15:0] panel_freq,
	input  wire logic        panel_run,
	// Configured external sources, same clock
	input  wire logic [15:0] ext_freq,
	input  wire logic        ext_run,
	// Drive feedback
	input  wire logic        motor_stopped,
	input  wire logic        power_lost,
	// Commands to the drive
	output logic      [15:0] freq_cmd,
	output logic             run_cmd,
	output logic             forced_stop,
	output logic             override_active
);
	// Saturating 16-bit sum
	function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = s[16] ? 16'hffff : s[15:0];
	endfunction

	// Software registers
	logic [31:0] ctrl_r;
	logic [15:0] fset_r;
	logic [15:0] fmax_r;
	logic [15:0] offset_r;
	logic [31:0] accel_r;
	logic [31:0] decel_r;
	logic [31:0] insel_a_r;
	logic [31:0] insel_b_r;
	logic [7:0]  fn_code [NPIN];
	logic [NPIN-1:0] pin_clean;

	// Per-pin function codes, one byte each
	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			fn_code[i] = (i < 4) ? insel_a_r[8*(i%4) +: 8] : insel_b_r[8*(i%4) +: 8];
		end
	end

	// Any pin carrying the given function and held on
	function automatic logic fn_on(input logic [7:0] code, input logic [NPIN-1:0] lvl,
			input logic [7:0] codes [NPIN]);
		fn_on = 1'b0;
		for (int i = 0; i < NPIN; i++) begin
			if (codes[i] == code && lvl[i]) fn_on = 1'b1;
		end
	endfunction

	fcm_pin_filter #(
		.WIDTH      (NPIN),
		.STABLE_CYC (DEBOUNCE_CYC)
	) u_filter (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_raw   (input_pins),
		.pin_clean (pin_clean)
	);

	logic up_in, dn_in, clr_in, ovr_in, add_in, jog_in;
	assign up_in  = fn_on(`FCM_FN_UP, pin_clean, fn_code);
	assign dn_in  = fn_on(`FCM_FN_DOWN, pin_clean, fn_code);
	assign clr_in = fn_on(`FCM_FN_CLR, pin_clean, fn_code);
	assign ovr_in = fn_on(`FCM_FN_OVR, pin_clean, fn_code);
	assign add_in = fn_on(`FCM_FN_ADD, pin_clean, fn_code);
	assign jog_in = fn_on(`FCM_FN_JOG, pin_clean, fn_code);

	fcm_state_type state_r;
	logic          ud_used_r;
	logic [15:0]   ud_r;
	logic [15:0]   base_freq;
	logic [15:0]   sum_freq;
	logic [1:0]    fsrc;
	logic [1:0]    rsrc;
	logic          oper_src;
	logic          ud_en;
	logic          up_go, dn_go;
	logic          ud_step;
	logic [15:0]   interval;

	assign fsrc = ctrl_r[`FCM_CTRL_FSRC_LSB +: 2];
	assign rsrc = ctrl_r[`FCM_CTRL_RSRC_LSB +: 2];
	// Override makes the panel the source as well
	assign oper_src = override_active || fsrc == `FCM_SRC_OPERATOR;
	assign ud_en = oper_src && !jog_in;
	assign up_go = ud_en && up_in && !dn_in;
	assign dn_go = ud_en && dn_in && !up_in;
	// Second set selected by software
	assign interval = ctrl_r[`FCM_CTRL_SET2_BIT] ?
		(up_go ? accel_r[31:16] : decel_r[31:16]) :
		(up_go ? accel_r[15:0] : decel_r[15:0]);

	// APB register writes, taken at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r    <= `FCM_RST_CTRL;
			fset_r    <= `FCM_RST_FSET;
			fmax_r    <= `FCM_RST_FMAX;
			offset_r  <= 16'h0000;
			accel_r   <= {`FCM_RST_RAMP, `FCM_RST_RAMP};
			decel_r   <= {`FCM_RST_RAMP, `FCM_RST_RAMP};
			insel_a_r <= `FCM_RST_INSEL_A;
			insel_b_r <= `FCM_RST_INSEL_B;
		end else if (psel && penable && pready && pwrite) begin
			case (paddr)
				`FCM_OFS_CTRL:    ctrl_r    <= pwdata & 32'h0003_0303;
				`FCM_OFS_FSET:    fset_r    <= pwdata[15:0];
				`FCM_OFS_FMAX:    fmax_r    <= pwdata[15:0];
				`FCM_OFS_OFFSET:  offset_r  <= pwdata[15:0];
				`FCM_OFS_ACCEL:   accel_r   <= pwdata;
				`FCM_OFS_DECEL:   decel_r   <= pwdata;
				`FCM_OFS_INSEL_A: insel_a_r <= pwdata;
				`FCM_OFS_INSEL_B: insel_b_r <= {16'h0000, pwdata[15:0]};
				default: ;
			endcase
		end
	end

	// Read data and answer prepared in the setup cycle, so the slave never waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				prdata <= 32'h0000_0000;
				case (paddr)
					`FCM_OFS_CTRL:    prdata <= ctrl_r;
					`FCM_OFS_FSET:    prdata <= {16'h0000, fset_r};
					`FCM_OFS_FMAX:    prdata <= {16'h0000, fmax_r};
					`FCM_OFS_OFFSET:  prdata <= {16'h0000, offset_r};
					`FCM_OFS_ACCEL:   prdata <= accel_r;
					`FCM_OFS_DECEL:   prdata <= decel_r;
					`FCM_OFS_INSEL_A: prdata <= insel_a_r;
					`FCM_OFS_INSEL_B: prdata <= insel_b_r;
					`FCM_OFS_STATUS: begin
						prdata[15:0]                  <= freq_cmd;
						prdata[`FCM_STAT_OVR_BIT]     <= override_active;
						prdata[`FCM_STAT_UDM_BIT]     <= ud_used_r;
						prdata[`FCM_STAT_RUN_BIT]     <= run_cmd;
						prdata[`FCM_STAT_STOP_BIT]    <= forced_stop;
						prdata[`FCM_STAT_PIN_LSB +: 6] <= 6'(pin_clean);
					end
					default: pslverr <= 1'b1; // Unmapped offset
				endcase
			end
		end
	end

	// Microsecond tick and step timer; each step is one frequency unit
	logic [15:0] tick_cnt_r;
	logic [15:0] step_cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 16'h0000;
			step_cnt_r <= 16'h0000;
			ud_step    <= 1'b0;
		end else begin
			ud_step <= 1'b0;
			if (!(up_go || dn_go)) begin
				// Restart the interval so a short press cannot inherit old progress
				tick_cnt_r <= 16'h0000;
				step_cnt_r <= 16'h0000;
			end else if (tick_cnt_r >= 16'(`FCM_TICK_CYC - 1)) begin
				tick_cnt_r <= 16'h0000;
				if (step_cnt_r + 16'h0001 >= interval) begin
					step_cnt_r <= 16'h0000;
					ud_step    <= 1'b1;
				end else begin
					step_cnt_r <= step_cnt_r + 16'h0001;
				end
			end else begin
				tick_cnt_r <= tick_cnt_r + 16'h0001;
			end
		end
	end

	// Up/down memory: tracks the stored setting until adjusted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ud_r      <= 16'h0000;
			ud_used_r <= 1'b0;
		end else if (clr_in) begin
			ud_r      <= fset_r;
			ud_used_r <= 1'b0;
		end else if (power_lost && !ctrl_r[`FCM_CTRL_MEM_BIT]) begin
			ud_r      <= fset_r;
			ud_used_r <= 1'b0;
		end else if (!ud_used_r && !(ud_step && (up_go || dn_go))) begin
			ud_r <= (fset_r > fmax_r) ? fmax_r : fset_r;
		end else if (ud_step && up_go) begin
			ud_used_r <= 1'b1;
			ud_r      <= (ud_r >= fmax_r) ? fmax_r : ud_r + 16'h0001;
		end else if (ud_step && dn_go) begin
			ud_used_r <= 1'b1;
			ud_r      <= (ud_r == 16'h0000) ? 16'h0000 : ud_r - 16'h0001;
		end else if (ud_r > fmax_r) begin
			ud_r <= fmax_r;
		end
	end

	// Frequency source choice, then offset on any source
	always_comb begin
		if (override_active) begin
			base_freq = ud_used_r ? ud_r : panel_freq;
		end else if (fsrc == `FCM_SRC_OPERATOR) begin
			base_freq = ud_r;
		end else begin
			base_freq = ext_freq;
		end
		sum_freq = add_in ? sat_add(base_freq, offset_r) : base_freq;
	end

	// Override hand-over: stop first when running, then apply
	logic panel_run_d_r;
	logic ovr_req;
	logic panel_press;
	logic driving;
	assign panel_press = panel_run && !panel_run_d_r;
	// Commanded or still turning; a panel re-press always finds run_cmd already low
	assign driving = run_cmd || !motor_stopped;
	assign ovr_req = (ovr_in != override_active) ||
		(override_active && ovr_in && panel_press && driving);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r         <= FCM_NORMAL;
			override_active <= 1'b0;
			forced_stop     <= 1'b0;
			panel_run_d_r   <= 1'b0;
		end else begin
			panel_run_d_r <= panel_run;
			case (state_r)
				FCM_NORMAL: begin
					if (ovr_req && driving) begin
						state_r     <= FCM_STOPPING;
						forced_stop <= 1'b1;
					end else if (ovr_in != override_active) begin
						override_active <= ovr_in;
					end
				end
				FCM_STOPPING: begin
					if (motor_stopped) begin
						state_r <= FCM_APPLY;
					end
				end
				FCM_APPLY: begin
					override_active <= ovr_in;
					forced_stop     <= 1'b0;
					state_r         <= FCM_NORMAL;
				end
				default: begin
					state_r     <= FCM_NORMAL;
					forced_stop <= 1'b0;
				end
			endcase
		end
	end

	// Drive commands, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_cmd <= 16'h0000;
			run_cmd  <= 1'b0;
		end else begin
			freq_cmd <= sum_freq;
			if (state_r != FCM_NORMAL || (ovr_req && driving)) begin
				run_cmd <= 1'b0;
			end else if (override_active || rsrc == `FCM_SRC_OPERATOR) begin
				run_cmd <= panel_run;
			end else begin
				run_cmd <= ext_run;
			end
		end
	end

	a_ud_clamp: assert property (@(posedge pclk) disable iff (!presetn)
		ud_used_r |-> ud_r <= fmax_r || $changed(fmax_r)
	) else $error("adjusted frequency above maximum");

	a_up_step: assert property (@(posedge pclk) disable iff (!presetn)
		(ud_step && up_go && !clr_in && !power_lost && ud_r < fmax_r) |=>
			ud_r == $past(ud_r) + 16'h0001
	) else $error("up step did not raise frequency by one");

	a_dn_step: assert property (@(posedge pclk) disable iff (!presetn)
		(ud_step && dn_go && !clr_in && !power_lost && ud_r != 16'h0000) |=>
			ud_r == $past(ud_r) - 16'h0001
	) else $error("down step did not lower frequency by one");

	a_both_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(up_in && dn_in && ud_used_r && !clr_in && !power_lost && $stable(fmax_r)) |=>
			$stable(ud_r)
	) else $error("frequency moved with up and down both on");

	a_clear_mem: assert property (@(posedge pclk) disable iff (!presetn)
		clr_in |=> !ud_used_r && ud_r == $past(fset_r)
	) else $error("clear did not restore set frequency");

	a_src_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(!ud_en || jog_in) |=> !$rose(ud_used_r)
	) else $error("up/down acted outside operator source");

	a_add_offset: assert property (@(posedge pclk) disable iff (!presetn)
		(add_in && base_freq <= 16'hffff - offset_r) |=>
			freq_cmd == $past(base_freq) + $past(offset_r)
	) else $error("offset not applied to frequency");

	a_no_offset: assert property (@(posedge pclk) disable iff (!presetn)
		!add_in |=> freq_cmd == $past(base_freq)
	) else $error("offset applied with add input off");

	a_ovr_stop: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == FCM_NORMAL && ovr_in != override_active && run_cmd) |=>
			forced_stop && !run_cmd ##1 !run_cmd
	) else $error("override change did not stop motor first");

	a_ramp_period: assert property (@(posedge pclk) disable iff (!presetn)
		ud_step |=> !ud_step
	) else $error("ramp steps too close together");
endmodule
`default_nettype wire

/* sim/fcm_partner.sv */
// Contact and keypad model standing at the far side of the modifier
`timescale 1ns/10ps
`default_nettype none
module fcm_partner
	import fcm_pkg::*;
#(
	parameter int NPIN   = 6,
	parameter int MIN_ON = 300
) (
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// Requests from the bench
	input  wire logic [NPIN-1:0] want_pins,
	input  wire logic [15:0]     want_freq,
	input  wire logic            want_run,
	// Contacts and keypad
	output logic      [NPIN-1:0] input_pins,
	output logic      [15:0]     panel_freq,
	output logic                 panel_run
);
	int on_cnt [NPIN];

	// A contact stays closed for its minimum on time, even if released early
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_pins <= '0;
			for (int i = 0; i < NPIN; i++) on_cnt[i] <= 0;
		end else begin
			for (int i = 0; i < NPIN; i++) begin
				if (want_pins[i]) input_pins[i] <= 1'b1;
				else if (on_cnt[i] >= MIN_ON) input_pins[i] <= 1'b0;
				on_cnt[i] <= input_pins[i] ? on_cnt[i] + 1 : 0;
			end
		end
	end

	// Keypad levels change only after a clock edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_freq <= 16'h0000;
			panel_run  <= 1'b0;
		end else begin
			panel_freq <= want_freq;
			panel_run  <= want_run;
		end
	end
endmodule
`default_nettype wire

/* sim/test_freq_command_modifier.sv */
// Self-checking bench for the frequency command modifier
`timescale 1ns/10ps
`default_nettype none
`include "fcm_defines.svh"
module test_freq_command_modifier
	import fcm_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        ext_run, motor_stopped, power_lost, run_cmd, forced_stop;
	logic        override_active, want_run, panel_run;
	logic [5:0]  want_pins, input_pins;
	logic [15:0] ext_freq, want_freq, panel_freq, freq_cmd, held;
	int          n_mismatch, tests_run;

	fcm_top #(.NPIN(6), .DEBOUNCE_CYC(4)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .input_pins(input_pins),
		.panel_freq(panel_freq), .panel_run(panel_run), .ext_freq(ext_freq),
		.ext_run(ext_run), .motor_stopped(motor_stopped), .power_lost(power_lost),
		.freq_cmd(freq_cmd), .run_cmd(run_cmd), .forced_stop(forced_stop),
		.override_active(override_active));

	fcm_partner #(.NPIN(6), .MIN_ON(300)) u_far (.pclk(pclk), .presetn(presetn),
		.want_pins(want_pins), .want_freq(want_freq), .want_run(want_run),
		.input_pins(input_pins), .panel_freq(panel_freq), .panel_run(panel_run));

	// Free-running 4 ns clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wt(int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; held until pready is seen, then released
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Close contacts for n cycles; the wait covers minimum on time and filter
	task automatic hold(logic [5:0] p, int n);
		want_pins <= p;
		wt(n);
		want_pins <= 6'h00;
		wt(400);
	endtask

	task automatic pwr_loss();
		power_lost <= 1'b1;
		wt(1);
		power_lost <= 1'b0;
		wt(5);
	endtask

	task automatic t_regs();
		logic [7:0]  ofs [5] = '{`FCM_OFS_CTRL, `FCM_OFS_FMAX, `FCM_OFS_ACCEL,
			`FCM_OFS_INSEL_A, `FCM_OFS_INSEL_B};
		logic [31:0] rv [5] = '{`FCM_RST_CTRL, 32'h0000_1770, 32'h03e8_03e8,
			`FCM_RST_INSEL_A, `FCM_RST_INSEL_B};
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ofs[i], 32'h0);
			chk("reset value", rd, rv[i]);
		end
		apb(1'b1, 8'h24, 32'h1234);
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped data", rd, 32'h0);
		chk("unmapped err", 32'(err), 32'h1);
	endtask

	// Up, down, both, jog and clear under operator source
	task automatic t_ramp();
		apb(1'b1, `FCM_OFS_ACCEL, 32'h0001_0001);
		apb(1'b1, `FCM_OFS_DECEL, 32'h0001_0001);
		apb(1'b1, `FCM_OFS_FSET, 32'h64);
		apb(1'b1, `FCM_OFS_CTRL, 32'h2);
		wt(10);
		chk("start value", 32'(freq_cmd), 32'h64);
		hold(6'h01, 1300);
		chk("up raises", 32'(freq_cmd > 16'h64), 32'h1);
		held = freq_cmd;
		wt(600);
		chk("up hold", 32'(freq_cmd), 32'(held));
		hold(6'h02, 600);
		chk("down lowers", 32'(freq_cmd < held), 32'h1);
		held = freq_cmd;
		hold(6'h03, 1000);
		chk("both hold", 32'(freq_cmd), 32'(held));
		hold(6'h21, 1000);
		chk("jog blocks", 32'(freq_cmd), 32'(held));
		hold(6'h04, 50);
		chk("clear", 32'(freq_cmd), 32'h64);
	endtask

	// Memory through power loss, then the clamp at both ends
	task automatic t_mem();
		hold(6'h01, 800);
		pwr_loss();
		chk("no memory", 32'(freq_cmd), 32'h64);
		apb(1'b1, `FCM_OFS_CTRL, 32'h0001_0002);
		hold(6'h01, 800);
		held = freq_cmd;
		pwr_loss();
		chk("memory kept", 32'(freq_cmd), 32'(held));
		apb(1'b1, `FCM_OFS_FSET, 32'h3);
		hold(6'h04, 50);
		hold(6'h02, 1500);
		chk("floor", 32'(freq_cmd), 32'h0);
		apb(1'b1, `FCM_OFS_FMAX, 32'h6);
		hold(6'h01, 2500);
		chk("ceiling", 32'(freq_cmd), 32'h6);
	endtask

	// External source: up ignored, offset added
	task automatic t_src();
		apb(1'b1, `FCM_OFS_CTRL, 32'h1);
		apb(1'b1, `FCM_OFS_OFFSET, 32'h10);
		wt(10);
		chk("ext source", 32'(freq_cmd), 32'h200);
		hold(6'h01, 1000);
		chk("up ignored", 32'(freq_cmd), 32'h200);
		want_pins <= 6'h10;
		wt(400);
		chk("offset on", 32'(freq_cmd), 32'h210);
		want_pins <= 6'h00;
		wt(400);
		chk("offset off", 32'(freq_cmd), 32'h200);
	endtask

	// Override while running: stop first, then panel; release restores
	task automatic t_ovr();
		// Drop the leftover up/down memory so the panel frequency is what shows
		hold(6'h04, 50);
		motor_stopped <= 1'b0;
		wt(5);
		chk("ext run", 32'(run_cmd), 32'h1);
		want_pins <= 6'h08;
		for (int i = 0; i < 50 && forced_stop !== 1'b1; i++) @(posedge pclk);
		chk("stop first", 32'(run_cmd), 32'h0);
		chk("not yet", 32'(override_active), 32'h0);
		motor_stopped <= 1'b1;
		wt(10);
		chk("override", 32'(override_active), 32'h1);
		chk("panel freq", 32'(freq_cmd), 32'h77);
		chk("panel run", 32'(run_cmd), 32'h1);
		// Panel run pressed again while the motor still turns
		motor_stopped <= 1'b0;
		want_run <= 1'b0;
		wt(3);
		want_run <= 1'b1;
		for (int i = 0; i < 20 && forced_stop !== 1'b1; i++) @(posedge pclk);
		chk("panel rerun stop", 32'(forced_stop), 32'h1);
		chk("panel rerun halt", 32'(run_cmd), 32'h0);
		motor_stopped <= 1'b1;
		wt(10);
		chk("panel rerun run", 32'(run_cmd), 32'h1);
		chk("panel rerun ovr", 32'(override_active), 32'h1);
		want_pins <= 6'h00;
		wt(400);
		chk("released", 32'(override_active), 32'h0);
		chk("ext again", 32'(freq_cmd), 32'h200);
	endtask

	// Up reassigned to the sixth input, then the second ramp set
	task automatic t_assign();
		apb(1'b1, `FCM_OFS_INSEL_B, 32'h1b32);
		apb(1'b1, `FCM_OFS_FMAX, 32'h1770);
		apb(1'b1, `FCM_OFS_CTRL, 32'h2);
		wt(10);
		held = freq_cmd;
		hold(6'h20, 1000);
		chk("sixth input up", 32'(freq_cmd > held), 32'h1);
		// Four ticks a step: one step in this press, the first set would give five
		apb(1'b1, `FCM_OFS_ACCEL, 32'h0004_0001);
		apb(1'b1, `FCM_OFS_CTRL, 32'h0002_0002);
		held = freq_cmd;
		hold(6'h20, 1300);
		chk("second ramp set", 32'(freq_cmd), 32'(held + 16'h0001));
	endtask

	task automatic conclude();
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run of about 20000 cycles
	initial begin
		wt(60000);
		n_mismatch++;
		conclude();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, power_lost} = '0;
		{want_pins, want_freq, want_run, ext_run} = '0;
		ext_freq = 16'h200;
		motor_stopped = 1'b1;
		n_mismatch = 0;
		tests_run = 0;
		wt(2);
		presetn <= 1'b1;
		ext_run <= 1'b1;
		want_freq <= 16'h77;
		want_run <= 1'b1;
		wt(1);
		t_regs();
		t_ramp();
		t_mem();
		t_src();
		t_ovr();
		t_assign();
		conclude();
	end
endmodule
`default_nettype wire
